// [common/spc_params.svh]
/*
 Timing counts, field positions and mode codes of the sleep controller.
 Included by the package and the design; definitions only.
*/
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_MODE_W 3
`define SPC_MODE_IDLE 3'h0
`define SPC_MODE_PDOWN 3'h1
`define SPC_MODE_PSAVE 3'h2
`define SPC_MODE_STDBY 3'h3
`define SPC_MODE_ESTDBY 3'h4
`define SPC_HALT_CYCLES 3'h4
`define SPC_HALT_W 3
`define SPC_WAKE_TWI 0
`define SPC_WAKE_PORT 1

`endif

// [common/spc_pkg.sv]
/*
 Types of the sleep and power controller.
 Assumes spc_params.svh on the include path.
*/
`include "spc_params.svh"

package spc_pkg;

    typedef logic [`SPC_MODE_W-1:0] spc_mode_t;

    typedef enum logic [2:0] {
        SPC_ACTIVE,
        SPC_WAIT_NVM,
        SPC_SLEEP,
        SPC_HALT,
        SPC_RESET
    } spc_state_t;

endpackage : spc_pkg

// [core/spc_sleep_ctrl.sv]
/*
 Sleep and power controller: sleep entry on the sleep instruction, clock
 gating per mode and per peripheral, qualified wake-up and a fixed halt.
 Assumes all inputs come from logic on clk, apart from the asynchronous
 wake pins, which are synchronised here.
*/
`timescale 1ns/100ps
`include "spc_params.svh"


module spc_sleep_ctrl #(
    parameter int NUM_PERIPH = 8,
    parameter logic PSAVE_RTC_ON = 1'b1,
    parameter logic STDBY_OSC_ON = 1'b1,
    parameter logic ESTDBY_RTC_ON = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Software settings
    input wire logic sleep_enable,
    input wire spc_pkg::spc_mode_t sleep_mode,
    input wire logic [NUM_PERIPH-1:0] periph_stop,
    // CPU and interrupt controller
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic twi_addr_match_irq,
    input wire logic port_async_irq,
    input wire logic reset_request,
    input wire logic nvm_busy,
    // Gating and status outputs
    output logic cpu_clk_en,
    output logic nvm_clk_en,
    output logic periph_clk_en_all,
    output logic [NUM_PERIPH-1:0] periph_clk_en,
    output logic rtc_clk_en,
    output logic osc_en,
    output logic cpu_halt,
    output logic wake_irq_go,
    output logic core_reset,
    output logic asleep
);
    import spc_pkg::*;

    // Elaboration checks on what the counters and vectors can serve
    if (NUM_PERIPH < 1 || NUM_PERIPH > 64)
    begin : g_bad_periph
        $error("NUM_PERIPH out of range");
    end

    if (`SPC_HALT_CYCLES == 0)
    begin : g_bad_halt
        $error("halt count must be at least one");
    end

    // The halt state counts down to zero, so it loads one less than the
    // number of halted cycles
    localparam logic [`SPC_HALT_W-1:0] HALT_LOAD = `SPC_HALT_CYCLES - 3'h1;

    // ------------------------------------------------------------
    // Synchronisers for asynchronous wake pins
    // ------------------------------------------------------------
    // Only the second stage is read: the first may be metastable
    logic [1:0] async_s1_reg, async_s1_next;
    logic [1:0] async_s2_reg, async_s2_next;

    always_comb
    begin
        async_s1_next = async_s1_reg;
        async_s2_next = async_s2_reg;
        if (clk_en)
        begin
            async_s1_next[`SPC_WAKE_TWI] = twi_addr_match_irq;
            async_s1_next[`SPC_WAKE_PORT] = port_async_irq;
            async_s2_next = async_s1_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            async_s1_reg <= 2'h0;
            async_s2_reg <= 2'h0;
        end
        else
        begin
            async_s1_reg <= async_s1_next;
            async_s2_reg <= async_s2_next;
        end
    end

    // ------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------
    spc_state_t state_reg, state_next;
    spc_mode_t mode_reg, mode_next;
    logic [`SPC_HALT_W-1:0] halt_cnt_reg, halt_cnt_next;
    logic wake_ok;
    logic irq_allowed;
    logic async_allowed;

    // Undefined mode codes gate like power-down and so wake like it
    always_comb
    begin
        irq_allowed = 1'b0;
        async_allowed = 1'b0;
        case (mode_reg)
            `SPC_MODE_IDLE:
                irq_allowed = 1'b1;
            `SPC_MODE_PDOWN:
                async_allowed = 1'b1;
            `SPC_MODE_PSAVE,
            `SPC_MODE_ESTDBY:
            begin
                irq_allowed = 1'b1;
                async_allowed = 1'b1;
            end
            `SPC_MODE_STDBY:
                async_allowed = 1'b1;
            default:
                async_allowed = 1'b1;
        endcase
        wake_ok = (irq_allowed && irq_pending)
                  || (async_allowed && |async_s2_reg);
    end

    // ------------------------------------------------------------
    // Sleep sequencer
    // ------------------------------------------------------------
    // Entry waits with the CPU stopped until programming ends; the mode is
    // latched at the sleep instruction so that later writes to the setting
    // do not change a sleep already under way
    always_comb
    begin
        state_next = state_reg;
        mode_next = mode_reg;
        halt_cnt_next = halt_cnt_reg;
        if (clk_en)
        begin
            case (state_reg)
                SPC_ACTIVE:
                    if (sleep_instr && sleep_enable)
                    begin
                        mode_next = sleep_mode;
                        state_next = SPC_WAIT_NVM;
                    end
                SPC_WAIT_NVM:
                    if (reset_request)
                        state_next = SPC_RESET;
                    else if (!nvm_busy)
                        state_next = SPC_SLEEP;
                SPC_SLEEP:
                    // A reset request wins over a wake in the same cycle
                    if (reset_request)
                        state_next = SPC_RESET;
                    else if (wake_ok)
                    begin
                        state_next = SPC_HALT;
                        halt_cnt_next = HALT_LOAD;
                    end
                SPC_HALT:
                    if (halt_cnt_reg == 3'h0)
                        state_next = SPC_ACTIVE;
                    else
                        halt_cnt_next = halt_cnt_reg - 3'h1;
                SPC_RESET:
                    state_next = SPC_ACTIVE;
                default:
                    state_next = SPC_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= SPC_ACTIVE;
            mode_reg <= `SPC_MODE_IDLE;
            halt_cnt_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            halt_cnt_reg <= halt_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Clock gating and status outputs
    // ------------------------------------------------------------
    // Outputs register the next state, so they change on the same edge
    // as the state that they describe
    logic cpu_en_next, nvm_en_next, per_all_next, rtc_next, osc_next;
    logic halt_next, go_next, rst_next, asleep_next;
    logic [NUM_PERIPH-1:0] per_en_next;
    logic sleeping;

    always_comb
    begin
        // Sleep only gates clocks and keeps all storage; core_reset comes from a reset request alone
        sleeping = state_next == SPC_SLEEP;
        cpu_en_next = !sleeping && state_next != SPC_WAIT_NVM;
        nvm_en_next = !sleeping;
        per_all_next = 1'b1;
        rtc_next = 1'b1;
        osc_next = 1'b1;
        if (sleeping)
        begin
            case (mode_next)
                `SPC_MODE_IDLE:
                    per_all_next = 1'b1;
                `SPC_MODE_PDOWN:
                begin
                    per_all_next = 1'b0;
                    rtc_next = 1'b0;
                    osc_next = 1'b0;
                end
                `SPC_MODE_PSAVE:
                begin
                    per_all_next = 1'b0;
                    rtc_next = PSAVE_RTC_ON;
                    osc_next = PSAVE_RTC_ON;
                end
                `SPC_MODE_STDBY:
                begin
                    per_all_next = 1'b0;
                    rtc_next = 1'b0;
                    osc_next = STDBY_OSC_ON;
                end
                `SPC_MODE_ESTDBY:
                begin
                    per_all_next = 1'b0;
                    rtc_next = ESTDBY_RTC_ON;
                    osc_next = STDBY_OSC_ON;
                end
                default:
                begin
                    per_all_next = 1'b0;
                    rtc_next = 1'b0;
                    osc_next = 1'b0;
                end
            endcase
        end
        for (int i = 0; i < NUM_PERIPH; i++)
        begin
            per_en_next[i] = per_all_next && !periph_stop[i];
        end
        halt_next = state_next != SPC_ACTIVE;
        // One pulse as the halt ends hands the core to its interrupt
        go_next = state_reg == SPC_HALT && state_next == SPC_ACTIVE;
        rst_next = state_next == SPC_RESET;
        asleep_next = sleeping;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cpu_clk_en <= 1'b1;
            nvm_clk_en <= 1'b1;
            periph_clk_en_all <= 1'b1;
            periph_clk_en <= {NUM_PERIPH{1'b1}};
            rtc_clk_en <= 1'b1;
            osc_en <= 1'b1;
            cpu_halt <= 1'b0;
            wake_irq_go <= 1'b0;
            core_reset <= 1'b0;
            asleep <= 1'b0;
        end
        else if (clk_en)
        begin
            cpu_clk_en <= cpu_en_next;
            nvm_clk_en <= nvm_en_next;
            periph_clk_en_all <= per_all_next;
            periph_clk_en <= per_en_next;
            rtc_clk_en <= rtc_next;
            osc_en <= osc_next;
            cpu_halt <= halt_next;
            wake_irq_go <= go_next;
            core_reset <= rst_next;
            asleep <= asleep_next;
        end
    end

endmodule : spc_sleep_ctrl

// [verification/spc_sleep_ctrl_assertions.sv]
/* Sleep controller assertions on the top ports.
   Bound to the design from the bench top file. */
`timescale 1ns/100ps
`include "spc_params.svh"
module spc_sleep_ctrl_assertions #(
    parameter int NUM_PERIPH = 8
) (
    // Core side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sleep_enable,
    input wire spc_pkg::spc_mode_t sleep_mode,
    input wire logic [NUM_PERIPH-1:0] periph_stop,
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic reset_request,
    input wire logic nvm_busy,
    // Gating and status
    input wire logic cpu_clk_en,
    input wire logic nvm_clk_en,
    input wire logic periph_clk_en_all,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en,
    input wire logic rtc_clk_en,
    input wire logic cpu_halt,
    input wire logic wake_irq_go,
    input wire logic core_reset,
    input wire logic asleep
);
    import spc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Mode taken at the sleep instruction, as the design latches it
    spc_mode_t mode_seen;

    always_ff @(posedge clk)
    begin
        if (rst_n && clk_en && sleep_instr && sleep_enable && !cpu_halt)
            mode_seen <= sleep_mode;
    end

    AST_ENTRY: assert property (clk_en && sleep_instr && sleep_enable
        && !cpu_halt && !asleep && !core_reset |=> cpu_halt)
        else $error("sleep entry missed");
    AST_SLEEP_GATE: assert property (asleep |-> !cpu_clk_en && !nvm_clk_en)
        else $error("core clocks on in sleep");
    AST_NVM_WAIT: assert property (nvm_busy && !asleep |=> !asleep)
        else $error("slept during programming");
    AST_HALT: assert property ($fell(asleep) && $past(rst_n)
        && !$past(reset_request) |-> cpu_halt [*4] ##1 (!cpu_halt && wake_irq_go))
        else $error("halt not four cycles");
    AST_IDLE_WAKE: assert property (clk_en && asleep && irq_pending
        && mode_seen == `SPC_MODE_IDLE && !reset_request |=> !asleep)
        else $error("idle did not wake");
    AST_IDLE_RUN: assert property (asleep && $past(clk_en)
        && mode_seen == `SPC_MODE_IDLE |-> periph_clk_en_all
        && periph_clk_en == ~$past(periph_stop))
        else $error("idle peripheral gating wrong");
    AST_PDOWN: assert property (asleep
        && mode_seen == `SPC_MODE_PDOWN |-> !periph_clk_en_all
        && !rtc_clk_en && periph_clk_en == '0)
        else $error("clock left on in power-down");
    AST_RESET: assert property (clk_en && asleep && reset_request
        |-> ##[1:2] core_reset)
        else $error("no reset from sleep");
    AST_PSTOP: assert property (clk_en && !cpu_halt && !asleep && !core_reset
        && !sleep_instr |=> periph_clk_en == ~$past(periph_stop))
        else $error("peripheral stop ignored");
endmodule : spc_sleep_ctrl_assertions

// [verification/spc_irq_model.sv]
/* Interrupt controller stand-in: a request stays pending until the core
   is released to serve it. Runs on the bench clock. */
`timescale 1ns/100ps
module spc_irq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request and service
    input wire logic raise,
    input wire logic wake_irq_go,
    output logic irq_pending
);
    always_ff @(posedge clk)
    begin
        if (!rst_n || wake_irq_go)
            irq_pending <= 1'b0;
        else if (raise)
            irq_pending <= 1'b1;
    end
endmodule : spc_irq_model

// [verification/sleep_power_controller_tb.sv]
/* Bench top: drives the core side at the falling edge and compares the
   status word with fixed expected values. Needs the design and package. */
`timescale 1ns/100ps
module sleep_power_controller_tb;
    import spc_pkg::*;
    logic clk = 0, rst_n = 0, clk_en = 1, sleep_enable = 1, sleep_instr = 0;
    logic raise = 0, twi = 0, port = 0, reset_request = 0, nvm_busy = 0;
    spc_mode_t sleep_mode = '0;
    logic [7:0] periph_stop = '0, periph_clk_en;
    logic cpu_clk_en, nvm_clk_en, periph_clk_en_all, rtc_clk_en, osc_en;
    logic cpu_halt, wake_irq_go, core_reset, asleep, irq_pending;
    wire [7:0] st = {cpu_clk_en, nvm_clk_en, periph_clk_en_all, rtc_clk_en,
        osc_en, cpu_halt, core_reset, asleep};
    int failures = 0, check_count = 0, seed = 32'h8b7e_957e, k, n;

    always #12.5 clk = ~clk;

    spc_sleep_ctrl u_spc_sleep_ctrl (.clk, .rst_n, .clk_en, .sleep_enable,
        .sleep_mode, .periph_stop, .sleep_instr, .irq_pending,
        .twi_addr_match_irq(twi), .port_async_irq(port), .reset_request,
        .nvm_busy, .cpu_clk_en, .nvm_clk_en, .periph_clk_en_all,
        .periph_clk_en, .rtc_clk_en, .osc_en, .cpu_halt, .wake_irq_go,
        .core_reset, .asleep);
    spc_irq_model u_spc_irq_model (.clk, .rst_n, .raise, .wake_irq_go,
        .irq_pending);

    task automatic chk(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (3)
        begin
            periph_stop = 8'($random(seed));
            @(negedge clk);
            chk("periph", periph_clk_en, ~periph_stop);
        end
        sleep_enable = 0;
        sleep_instr = 1;
        @(negedge clk);
        sleep_enable = 1;
        clk_en = 0;
        @(negedge clk);
        clk_en = 1;
        sleep_instr = 0;
        chk("refused", st, 8'hf8);
        for (int m = 0; m < 5; m++)
        begin
            @(negedge clk);
            sleep_mode = m[2:0];
            periph_stop = 8'($random(seed));
            sleep_instr = 1;
            @(negedge clk);
            sleep_instr = 0;
            chk("entry", st, 8'h7c);
            @(negedge clk);
            chk("asleep", st & (m < 2 ? 8'hff : 8'he7), m ? 8'h05 : 8'h3d);
            if (m < 2)
                chk("periph", periph_clk_en, m ? 8'h00 : ~periph_stop);
            raise = 1;
            for (k = 0; k < 12 && asleep === 1'b1; k++)
            begin
                @(negedge clk);
                raise = 0;
                if (k == 3)
                    {twi, port} = (m == 3) ? 2'b10 : 2'b01;
            end
            chk("wake", k[7:0], (m == 1 || m == 3) ? 8'h07 : 8'h02);
            chk("halt", st, 8'hfc);
            for (n = 0; n < 9 && cpu_halt === 1'b1; n++)
                @(negedge clk);
            {twi, port} = 2'b00;
            chk("halt len", n[7:0], 8'h04);
            chk("resume", {7'h0, wake_irq_go}, 8'h01);
        end
        nvm_busy = 1;
        sleep_mode = '0;
        sleep_instr = 1;
        @(negedge clk);
        sleep_instr = 0;
        repeat (2) @(negedge clk);
        chk("nvm wait", st & 8'h85, 8'h04);
        nvm_busy = 0;
        for (k = 0; k < 3 && asleep !== 1'b1; k++)
            @(negedge clk);
        chk("nvm done", st, 8'h3d);
        reset_request = 1;
        for (k = 0; k < 3 && core_reset !== 1'b1; k++)
            @(negedge clk);
        chk("reset", st & 8'h02, 8'h02);
        @(negedge clk);
        reset_request = 0;
        repeat (2) @(negedge clk);
        chk("restart", st & 8'h07, 8'h00);
        wrap_up();
    end
endmodule : sleep_power_controller_tb

bind spc_sleep_ctrl spc_sleep_ctrl_assertions #(.NUM_PERIPH(NUM_PERIPH))
    u_spc_sleep_ctrl_assertions (.clk, .rst_n, .clk_en, .sleep_enable,
    .sleep_mode, .periph_stop, .sleep_instr, .irq_pending, .reset_request,
    .nvm_busy, .cpu_clk_en, .nvm_clk_en, .periph_clk_en_all, .periph_clk_en,
    .rtc_clk_en, .cpu_halt, .wake_irq_go, .core_reset, .asleep);
